// *** include/sbstap_regs.vh ***
/*
 Constants of the SRAM test access port: instruction codes, register
 lengths, reset values and trace FIFO size. Definitions only.
*/
`ifndef SBSTAP_REGS_VH
`define SBSTAP_REGS_VH

`define SBSTAP_IR_W 3
`define SBSTAP_IR_EXTEST 3'h0
`define SBSTAP_IR_IDCODE 3'h1
`define SBSTAP_IR_SAMPZ 3'h2
`define SBSTAP_IR_SAMPLE 3'h4
`define SBSTAP_IR_BYPASS 3'h7
`define SBSTAP_IR_CAPTURE 3'h1
`define SBSTAP_ID_W 32
`define SBSTAP_BSR_W 90
`define SBSTAP_RESET_TMS_EDGES 5
`define SBSTAP_FIFO_W 1
`define SBSTAP_FIFO_D 16
`define SBSTAP_FIFO_AW 4
// Identification word: arbitrary neutral value, bit 0 set as presence mark
`define SBSTAP_ID_WORD 32'h1234_5679

`endif

// *** core/sbstap_fifo.v ***
/*
 Parameterised flip-flop FIFO with valid/ready on both sides.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module sbstap_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk, // System clock
    input wire rst_b, // Synchronous reset, active low
    input wire in_valid, // Write request
    output wire in_ready, // Not full
    input wire [WIDTH-1:0] in_data, // Write data
    output wire out_valid, // Not empty
    input wire out_ready, // Read accept
    output wire [WIDTH-1:0] out_data // Head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// *** core/sbstap_core.v ***
/*
 Test access port of a burst SRAM, oversampling the test clock on clk.
 Assumes clk runs well above the test clock (20 MHz against 2.5 MHz);
 tck, tms, tdi arrive asynchronously; the bench resolves tdo from the
 active-low enable. Boundary cells come in as a parallel snapshot.
*/
// Contract
// RQ1 - Inputs captured on test clock rise, output updated on its fall.
// RQ2 - Mode select sampled on each rise; undriven reads high.
// RQ3 - Loaded instruction picks the register between data in and out.
// RQ4 - Every scan register shifts in at its top bit toward bit zero.
// RQ5 - Data output shows selected register bit zero, changing on fall.
// RQ6 - Data output driven only in shift states, else high impedance.
// RQ7 - Five rises with mode select high reach reset from anywhere.
// RQ8 - Port reset leaves memory reads, writes and contents untouched.
// RQ9 - Power-up resets port internally; data output starts undriven.
// RQ10 - Exactly one scan register sits in the path at a time.
// RQ11 - Instruction register is three bits, shifted only when in path.
// RQ12 - Reset and power-up load the identification instruction.
// RQ13 - Instruction capture loads binary 01 into its two low bits.
// RQ14 - Bypass is one bit, a single stage of delay.
// RQ15 - Bypass bit cleared when bypass instruction takes effect.
// RQ16 - Codes: 000 extest, 001 id, 010 sample-z, 100 sample, 111 bypass.
// RQ17 - Id instruction capture loads the 32-bit identification word.
// RQ18 - Sample-z puts boundary register in path, memory outputs off.
// RQ19 - Standard sixteen-state controller steps on each test clock rise.
`timescale 1ns/1ps
`default_nettype none
`include "sbstap_regs.vh"

module sbstap_core (
    input wire clk, // System clock, 20 MHz
    input wire rst_b, // Synchronous reset (power-up), active low
    input wire tck, // Test clock pin
    input wire tms, // Mode select pin, pulled high outside
    input wire tdi, // Serial data in, pulled high outside
    output reg tdo_out, // Serial data out level
    output reg tdo_oe_b, // Serial out enable, low drives
    input wire [`SBSTAP_BSR_W-1:0] ring_in, // Snapshot of pin ring
    output wire mem_out_hiz, // Force memory drivers off
    output wire [`SBSTAP_IR_W-1:0] cur_instr, // Active instruction
    output wire shift_valid, // Shifted-out bit available
    input wire shift_ready, // Consumer takes shifted-out bit
    output wire [`SBSTAP_FIFO_W-1:0] shift_data, // Shifted-out bit
    output wire shift_stall // Trace buffer full, bits dropped
);
    localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SELDR = 16'h0004,
        S_CAPDR = 16'h0008, S_SHDR = 16'h0010, S_EX1DR = 16'h0020,
        S_PAUDR = 16'h0040, S_EX2DR = 16'h0080, S_UPDR = 16'h0100,
        S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR = 16'h0800,
        S_EX1IR = 16'h1000, S_PAUIR = 16'h2000, S_EX2IR = 16'h4000,
        S_UPIR = 16'h8000;

    // Two-stage synchronisers; stage one read only by stage two
    reg [2:0] sync1;
    reg [2:0] sync2;
    reg tck_prev;
    reg [15:0] state;
    reg [15:0] next_state;
    reg [`SBSTAP_IR_W-1:0] ir_shift;
    reg [`SBSTAP_IR_W-1:0] ir;
    reg bypass;
    reg [`SBSTAP_ID_W-1:0] id_reg;
    reg [`SBSTAP_BSR_W-1:0] bsr;
    reg sel_lsb;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire rise;
    wire fall;
    wire shifting;
    wire fifo_in_ready;

    assign tck_s = sync2[0];
    assign tms_s = sync2[1];
    assign tdi_s = sync2[2];
    assign rise = tck_s && !tck_prev; // see RQ1
    assign fall = !tck_s && tck_prev; // see RQ1
    assign shifting = (state == S_SHDR) || (state == S_SHIR);
    assign cur_instr = ir;

    // Decode used for path choice and for boundary capture and shift
    function is_boundary;
        input [`SBSTAP_IR_W-1:0] code;
        begin
            is_boundary = (code == `SBSTAP_IR_EXTEST) || (code == `SBSTAP_IR_SAMPZ) ||
                (code == `SBSTAP_IR_SAMPLE); // see RQ16
        end
    endfunction

    // Only extest and sample-z turn memory drivers off; nothing else reaches memory
    assign mem_out_hiz = (ir == `SBSTAP_IR_EXTEST) || (ir == `SBSTAP_IR_SAMPZ); // see RQ18 RQ8

    always @(posedge clk) begin
        if (!rst_b) begin
            // Test clock resets to its idle low level: no false rise after reset
            sync1 <= 3'h6;
            sync2 <= 3'h6;
            tck_prev <= 1'b0;
        end else begin
            sync1 <= {tdi, tms, tck};
            sync2 <= sync1;
            tck_prev <= tck_s;
        end
    end

    // Standard controller transitions; five TMS-high rises reach reset
    always @* begin
        next_state = S_TLR;
        case (state)
            S_TLR: next_state = tms_s ? S_TLR : S_RTI; // see RQ7
            S_RTI: next_state = tms_s ? S_SELDR : S_RTI;
            S_SELDR: next_state = tms_s ? S_SELIR : S_CAPDR;
            S_CAPDR: next_state = tms_s ? S_EX1DR : S_SHDR;
            S_SHDR: next_state = tms_s ? S_EX1DR : S_SHDR;
            S_EX1DR: next_state = tms_s ? S_UPDR : S_PAUDR;
            S_PAUDR: next_state = tms_s ? S_EX2DR : S_PAUDR;
            S_EX2DR: next_state = tms_s ? S_UPDR : S_SHDR;
            S_UPDR: next_state = tms_s ? S_SELDR : S_RTI;
            S_SELIR: next_state = tms_s ? S_TLR : S_CAPIR;
            S_CAPIR: next_state = tms_s ? S_EX1IR : S_SHIR;
            S_SHIR: next_state = tms_s ? S_EX1IR : S_SHIR;
            S_EX1IR: next_state = tms_s ? S_UPIR : S_PAUIR;
            S_PAUIR: next_state = tms_s ? S_EX2IR : S_PAUIR;
            S_EX2IR: next_state = tms_s ? S_UPIR : S_SHIR;
            S_UPIR: next_state = tms_s ? S_SELDR : S_RTI;
            default: next_state = S_TLR;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            state <= S_TLR; // see RQ9
            ir <= `SBSTAP_IR_IDCODE; // see RQ12
            ir_shift <= `SBSTAP_IR_CAPTURE;
            bypass <= 1'b0;
            id_reg <= {`SBSTAP_ID_W{1'b0}};
            bsr <= {`SBSTAP_BSR_W{1'b0}};
        end else if (rise) begin
            state <= next_state; // see RQ2 RQ19
            case (state)
                S_CAPIR: begin
                    ir_shift <= `SBSTAP_IR_CAPTURE; // see RQ13
                end
                S_SHIR: begin
                    ir_shift <= {tdi_s, ir_shift[`SBSTAP_IR_W-1:1]}; // see RQ4 RQ11
                end
                S_UPIR: begin
                    ir <= ir_shift;
                    if (ir_shift == `SBSTAP_IR_BYPASS) begin
                        bypass <= 1'b0; // see RQ15
                    end
                end
                S_CAPDR: begin
                    if (ir == `SBSTAP_IR_IDCODE) begin
                        id_reg <= `SBSTAP_ID_WORD; // see RQ17
                    end else if (is_boundary(ir)) begin
                        bsr <= ring_in;
                    end else begin
                        bypass <= 1'b0;
                    end
                end
                S_SHDR: begin
                    // Only the selected register moves; see RQ3 RQ10
                    if (ir == `SBSTAP_IR_IDCODE) begin
                        id_reg <= {tdi_s, id_reg[`SBSTAP_ID_W-1:1]}; // see RQ4
                    end else if (is_boundary(ir)) begin
                        bsr <= {tdi_s, bsr[`SBSTAP_BSR_W-1:1]}; // see RQ4 RQ18
                    end else begin
                        bypass <= tdi_s; // see RQ14
                    end
                end
                default: begin
                end
            endcase
            // Load on entry, so the fifth mode-select rise leaves the id code active
            if (next_state == S_TLR) begin
                ir <= `SBSTAP_IR_IDCODE; // see RQ12
            end
        end
    end

    // Reserved codes fall through to bypass, keeping one stage in the path
    always @* begin
        if (state == S_SHIR) begin
            sel_lsb = ir_shift[0];
        end else if (ir == `SBSTAP_IR_IDCODE) begin
            sel_lsb = id_reg[0];
        end else if (is_boundary(ir)) begin
            sel_lsb = bsr[0];
        end else begin
            sel_lsb = bypass;
        end
    end

    // Falling edge updates pin, after the rise has moved the shift register
    always @(posedge clk) begin
        if (!rst_b) begin
            tdo_out <= 1'b0;
            tdo_oe_b <= 1'b1; // see RQ9
        end else if (fall) begin
            tdo_out <= sel_lsb; // see RQ5
            tdo_oe_b <= !shifting; // see RQ6
        end
    end

    // Trace of every bit leaving the chain; drops bits once the 16-deep buffer is full
    sbstap_fifo #(
        .WIDTH(`SBSTAP_FIFO_W),
        .DEPTH(`SBSTAP_FIFO_D),
        .AW(`SBSTAP_FIFO_AW)
    ) u_trace (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(rise && shifting),
        .in_ready(fifo_in_ready),
        .in_data(sel_lsb),
        .out_valid(shift_valid),
        .out_ready(shift_ready),
        .out_data(shift_data)
    );
    assign shift_stall = !fifo_in_ready;
endmodule

`default_nettype wire

// *** tb/sbstap_core_properties.sv ***
/* Checker of the test port core, bound to its ports.
   Assumes clk oversamples tck through a two-stage synchroniser. */
`timescale 1ns/1ps
`default_nettype none
module sbstap_core_properties (
    input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire logic tck, // test clock
    input wire logic tdo_out, // data out
    input wire logic tdo_oe_b, // out enable
    input wire logic mem_out_hiz, // memory off
    input wire logic [2:0] cur_instr, // instruction
    input wire logic shift_valid, // trace valid
    input wire logic shift_ready, // trace pop
    input wire logic [0:0] shift_data, // trace head
    input wire logic shift_stall // trace full
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Pin low for two samples: a fall lies behind us
    sequence s_tck_low;
        !$past(tck, 1) && !$past(tck, 2);
    endsequence
    chk_reset_state: assert property ($rose(rst_b) |-> tdo_oe_b && cur_instr == 3'h1)
        else $error("port not in reset state");
    chk_tdo_on_fall: assert property ($changed(tdo_out) |-> s_tck_low)
        else $error("data out moved off a fall");
    chk_oe_on_fall: assert property ($changed(tdo_oe_b) |-> s_tck_low)
        else $error("out enable moved off a fall");
    chk_tdo_hold: assert property ($changed(tdo_out) |=> $stable(tdo_out) [*4])
        else $error("data out not held");
    chk_hiz_codes: assert property (mem_out_hiz == (cur_instr == 3'h0 || cur_instr == 3'h2))
        else $error("memory drivers wrong for code");
    chk_full_valid: assert property (shift_stall |-> shift_valid)
        else $error("full trace reads empty");
    chk_head_hold: assert property (shift_valid && !shift_ready |=> shift_valid && $stable(shift_data))
        else $error("trace head lost");
    chk_trace_rise: assert property ($rose(shift_valid) |-> $past(tck, 1))
        else $error("trace pushed off a rise");
endmodule
bind sbstap_core sbstap_core_properties u_props (.clk(clk), .rst_b(rst_b), .tck(tck),
    .tdo_out(tdo_out), .tdo_oe_b(tdo_oe_b), .mem_out_hiz(mem_out_hiz),
    .cur_instr(cur_instr), .shift_valid(shift_valid), .shift_ready(shift_ready),
    .shift_data(shift_data), .shift_stall(shift_stall));
`default_nettype wire

// *** tb/sbstap_ctl_model.sv ***
/* Boundary-scan controller model: one 400 ns test clock per step.
   Assumes the caller steps it from a single process. */
`timescale 1ns/1ps
`default_nettype none
module sbstap_ctl_model (
    output var logic tck, // test clock
    output var logic tms, // mode select
    output var logic tdi, // data to port
    input wire logic tdo_out, // data from port
    input wire logic tdo_oe_b // port enable
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // Data out read late in the high phase, where it is sure to be settled
    task step(input logic m, input logic d, output logic q, output logic z);
        tms = m;
        tdi = d;
        #200 tck = 1'b1;
        // Undriven pin has no pull: show the inverse so a stray read fails
        #190 q = tdo_oe_b ? !tdo_out : tdo_out;
        z = tdo_oe_b;
        tdi = 1'b1; // Released after the rise: pull-up level
        #10 tck = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/tb_sram_boundary_scan_tap.sv ***
/* Bench of the test port core driven through the controller model.
   Assumes the core, its FIFO, the checker and the model compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "sbstap_regs.vh"
module tb_sram_boundary_scan_tap;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic shift_ready = 1'b0;
    logic [`SBSTAP_BSR_W-1:0] ring_in = '0;
    wire tck, tms, tdi, tdo_out, tdo_oe_b, mem_out_hiz, shift_valid, shift_stall;
    wire [2:0] cur_instr;
    wire [0:0] shift_data;
    int fail_count = 0;
    int check_count = 0;
    logic q, z;
    logic [127:0] so;
    always #25 clk = ~clk;
    sbstap_core DUT (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo_out(tdo_out), .tdo_oe_b(tdo_oe_b), .ring_in(ring_in),
        .mem_out_hiz(mem_out_hiz), .cur_instr(cur_instr), .shift_valid(shift_valid),
        .shift_ready(shift_ready), .shift_data(shift_data), .shift_stall(shift_stall));
    sbstap_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
        .tdo_oe_b(tdo_oe_b));
    task ck(input string n, input logic [127:0] g, input logic [127:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Mode-select bits taken LSB first
    task moves(input logic [7:0] m, input int n);
        for (int i = 0; i < n; i++) ctl.step(m[i], 1'b1, q, z);
    endtask
    task dr(input int n, input logic [127:0] d);
        logic zo;
        zo = 1'b0;
        moves(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            ctl.step(i == n - 1, d[i], so[i], z);
            zo = zo | z;
        end
        ck("oe in shift", zo, 1'b0);
        moves(8'h01, 2);
        ck("oe idle", tdo_oe_b, 1'b1);
    endtask
    task ir(input logic [2:0] c);
        moves(8'h03, 4);
        for (int i = 0; i < 3; i++) ctl.step(i == 2, c[i], so[i], z);
        moves(8'h01, 2);
        ck("ir capture", so[1:0], 2'b01);
    endtask
    task t_power_up;
        ck("oe reset", tdo_oe_b, 1'b1);
        ck("instr reset", cur_instr, 3'h1);
        ck("trace empty", shift_valid, 1'b0);
    endtask
    // Trace left unread while 64 bits pass: it fills and refuses
    task t_idcode;
        dr(64, 128'hC3A5_5A3C);
        ck("id word", so[31:0], `SBSTAP_ID_WORD);
        ck("msb entry", so[63:32], 32'hC3A5_5A3C);
        ck("trace full", shift_stall, 1'b1);
        for (int i = 0; i < 16; i++) begin
            ck("trace data", shift_data, so[i]);
            @(negedge clk) shift_ready = 1'b1;
            @(negedge clk) shift_ready = 1'b0;
        end
        ck("trace drained", shift_valid, 1'b0);
        @(negedge clk) shift_ready = 1'b1;
    endtask
    task t_codes;
        logic [2:0] c [5] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h1};
        foreach (c[i]) begin
            ir(c[i]);
            ck("instr", cur_instr, c[i]);
            ck("mem hiz", mem_out_hiz, c[i] == 3'h0 || c[i] == 3'h2);
        end
    endtask
    task t_boundary;
        @(negedge clk) ring_in = {3{30'h2B5C_96E1}};
        ir(3'h2);
        dr(`SBSTAP_BSR_W, '0);
        ck("ring", so[`SBSTAP_BSR_W-1:0], ring_in);
    endtask
    // Reserved code behaves as bypass
    task t_bypass;
        logic [2:0] c [2] = '{3'h7, 3'h3};
        foreach (c[i]) begin
            ir(c[i]);
            dr(9, 128'hA5);
            ck("bypass clear", so[0], 1'b0);
            ck("bypass delay", so[8:1], 8'hA5);
        end
    endtask
    task t_mid_reset;
        ir(3'h4);
        moves(8'h01, 5);
        moves(8'h1F, 5);
        ck("instr tap reset", cur_instr, 3'h1);
        ck("oe tap reset", tdo_oe_b, 1'b1);
        moves(8'h00, 1);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        repeat (2) @(negedge clk);
        t_power_up;
        #7;
        moves(8'h3F, 7);
        t_idcode;
        t_codes;
        t_boundary;
        t_bypass;
        t_mid_reset;
        end_of_test;
    end
    initial begin
        #400000;
        fail_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
